// ---- right_entry_display_scan.sv ----
`timescale 1ns/1ps
module right_entry_display_scan
  import disp_scan_pkg::*;
#(
  parameter int prescale = PRESCALE_DEF
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       cs_n,
  input  wire logic       a0,
  input  wire logic       wr_n,
  input  wire logic [7:0] data_in,
  output logic      [3:0] scan_timing_outputs,
  output logic      [3:0] display_nibble_a,
  output logic      [3:0] display_nibble_b,
  output logic            blank_display_n,
  output logic            key_strobe,
  output logic            key_scan_done,
  output logic            debounce_done
);

  // ***************************************************************
  // reset release and pin synchronisers
  // ***************************************************************
  logic        rst_meta;
  logic        rst_n_s;
  logic [10:0] bus_meta;
  logic [10:0] bus_s;
  logic [10:0] bus_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n_s  <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_s  <= rst_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      bus_meta <= BUS_IDLE;
      bus_s    <= BUS_IDLE;
      bus_q    <= BUS_IDLE;
    end else begin
      bus_meta <= {cs_n, a0, wr_n, data_in};
      bus_s    <= bus_meta;
      bus_q    <= bus_s;
    end
  end

  // ***************************************************************
  // host write decode
  // ***************************************************************
  wire       wr_rise  = bus_s[WR_BIT] & ~bus_q[WR_BIT];
  wire       taken    = wr_rise & ~bus_q[CS_BIT];
  wire [7:0] host_byte = bus_q[7:0];
  wire [2:0] op       = host_byte[7:OP_LSB];
  wire       cmd_wr   = taken & bus_q[A0_BIT];
  wire       data_wr  = taken & ~bus_q[A0_BIT];
  wire       mode_set = cmd_wr && (op == OP_MODE_SET);
  wire       addr_set = cmd_wr && (op == OP_WRITE_DISP);

  logic          right_mode;
  logic          sixteen;
  logic          auto_increment_flag;
  logic [AW-1:0] wr_addr;
  logic [AW-1:0] entries;

  wire [AW-1:0] mask     = sixteen ? MASK_16 : MASK_8;
  wire [AW-1:0] ram_addr = wr_addr & mask;

  wire [AW-1:0] next_wr_addr =
    mode_set ? '0 :
    addr_set ? host_byte[AW-1:0] & mask :
    (data_wr && auto_increment_flag) ? (wr_addr + 4'h1) & mask : wr_addr;

  wire [AW-1:0] next_entries =
    mode_set ? '0 :
    (data_wr && right_mode) ? (entries + 4'h1) & mask : entries;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      right_mode          <= MODE_RESET[1];
      sixteen             <= MODE_RESET[0];
      auto_increment_flag <= 1'b0;
      wr_addr             <= '0;
      entries             <= '0;
    end else begin
      if (mode_set) begin
        right_mode <= host_byte[RIGHT_BIT];
        sixteen    <= host_byte[SIXTEEN_BIT];
      end
      if (addr_set) begin
        auto_increment_flag <= host_byte[AI_BIT];
      end
      wr_addr <= next_wr_addr;
      entries <= next_entries;
    end
  end

  // ***************************************************************
  // prescaler and scan counters
  // ***************************************************************
  logic [15:0] pre;
  logic [5:0]  slot_cnt;
  logic [3:0]  scan;
  logic        half;

  wire tick      = (pre == 16'(prescale - 1));
  wire slot_end  = tick && (slot_cnt == 6'(SLOT_TICKS - 1));
  wire line_wrap = slot_end && (scan[2:0] == 3'(SCAN_LINES - 1));
  wire blank_next = (slot_cnt < 6'(BLANK_TICKS));

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pre      <= '0;
      slot_cnt <= '0;
      scan     <= '0;
      half     <= 1'b0;
    end else begin
      pre <= tick ? '0 : pre + 16'h1;
      if (tick) begin
        slot_cnt <= slot_end ? '0 : slot_cnt + 6'h1;
      end
      if (slot_end) begin
        scan <= scan + 4'h1;
      end
      if (line_wrap) begin
        half <= ~half;
      end
    end
  end

  // ***************************************************************
  // display memory and position mapping
  // ***************************************************************
  logic [DW-1:0] rd_data;

  wire [AW-1:0] pos     = scan & mask;
  wire [AW-1:0] rd_addr = right_mode ? (entries - 4'h1 - pos) & mask : pos;

  disp_ram u_ram (
    .clk     (clk),
    .rst_n   (rst_n_s),
    .we      (data_wr),
    .wr_addr (ram_addr),
    .wr_data (host_byte),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ***************************************************************
  // registered outputs
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      scan_timing_outputs <= '0;
      display_nibble_a    <= '0;
      display_nibble_b    <= '0;
      blank_display_n     <= 1'b0;
      key_strobe          <= 1'b0;
      key_scan_done       <= 1'b0;
      debounce_done       <= 1'b0;
    end else begin
      scan_timing_outputs <= scan;
      display_nibble_a    <= blank_next ? 4'h0 : rd_data[7:4];
      display_nibble_b    <= blank_next ? 4'h0 : rd_data[3:0];
      blank_display_n     <= ~blank_next;
      key_strobe          <= tick && (slot_cnt[2:0] == 3'(KEY_TICKS - 1));
      key_scan_done       <= line_wrap;
      debounce_done       <= line_wrap && half;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  localparam int KEY_CYC   = KEY_TICKS * prescale;
  localparam int BLANK_CYC = BLANK_TICKS * prescale;
  localparam int LIT_CYC   = DIGIT_TICKS * prescale;

  logic [19:0] gap;
  logic [19:0] run;
  logic        strobe_seen;
  logic        run_valid;
  logic [1:0]  scans;
  logic        deb_seen;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      gap         <= '0;
      run         <= '0;
      strobe_seen <= 1'b0;
      run_valid   <= 1'b0;
      scans       <= '0;
      deb_seen    <= 1'b0;
    end else begin
      gap <= key_strobe ? 20'h1 : gap + 20'h1;
      if (key_strobe) begin
        strobe_seen <= 1'b1;
      end
      if (blank_display_n == blank_next) begin
        run       <= 20'h1;
        run_valid <= run_valid | blank_display_n;
      end else begin
        run <= run + 20'h1;
      end
      if (debounce_done) begin
        scans    <= '0;
        deb_seen <= 1'b1;
      end else if (key_scan_done) begin
        scans <= scans + 2'h1;
      end
    end
  end

  a_key_period: assert property (@(posedge clk) disable iff (!rst_n_s)
    key_strobe && strobe_seen |-> gap == 20'(KEY_CYC))
    else $error("key strobe spacing wrong");

  a_scan_line: assert property (@(posedge clk) disable iff (!rst_n_s)
    key_scan_done |-> key_strobe && scan_timing_outputs[2:0] == 3'h7)
    else $error("key scan end not on last line");

  a_debounce_pair: assert property (@(posedge clk) disable iff (!rst_n_s)
    debounce_done && deb_seen |-> key_scan_done && scans == 2'h1)
    else $error("debounce not two key scans");

  a_blank_len: assert property (@(posedge clk) disable iff (!rst_n_s)
    $rose(blank_display_n) && run_valid |-> $past(run) == 20'(BLANK_CYC))
    else $error("blank interval length wrong");

  a_digit_len: assert property (@(posedge clk) disable iff (!rst_n_s)
    $fell(blank_display_n) |-> $past(run) == 20'(LIT_CYC))
    else $error("lit digit length wrong");

  a_blank_both: assert property (@(posedge clk) disable iff (!rst_n_s)
    !blank_display_n |-> display_nibble_a == 4'h0 && display_nibble_b == 4'h0)
    else $error("nibbles live while blanked");

  a_nibble_map: assert property (@(posedge clk) disable iff (!rst_n_s)
    blank_display_n |-> {display_nibble_a, display_nibble_b} == $past(rd_data))
    else $error("nibble bit order wrong");

  a_cmd_addr: assert property (@(posedge clk) disable iff (!rst_n_s)
    cmd_wr && host_byte == CMD_NEXT_AT_5 |=> wr_addr == (ADDR_5 & mask) && auto_increment_flag)
    else $error("command 95 not taken");

  a_entry_shift: assert property (@(posedge clk) disable iff (!rst_n_s)
    data_wr && right_mode && !mode_set |=> entries == (($past(entries) + 4'h1) & mask))
    else $error("right entry did not shift");

  a_first_clear: assert property (@(posedge clk) disable iff (!rst_n_s)
    mode_set |=> entries == '0 && wr_addr == '0)
    else $error("mode set did not restart entry");

  a_first_entry: assert property (@(posedge clk) disable iff (!rst_n_s)
    right_mode && entries == 4'h1 && pos == 4'h0 |-> rd_addr == '0)
    else $error("first entry not rightmost");

endmodule

// ---- disp_scan_pkg.sv ----
package disp_scan_pkg;

  // ***************************************************************
  // clock and internal scan rate
  // ***************************************************************
  localparam int CLK_HZ        = 10_000_000;
  localparam int INT_CLK_HZ    = 100_000;
  localparam int PRESCALE_DEF  = CLK_HZ / INT_CLK_HZ;
  localparam int INT_PERIOD_NS = 1_000_000_000 / INT_CLK_HZ;

  // ***************************************************************
  // scan times, in microseconds and in internal ticks
  // ***************************************************************
  localparam int SINGLE_KEY_US = 80;
  localparam int BLANK_US      = 150;
  localparam int DIGIT_US      = 490;
  localparam int KEY_TICKS     = SINGLE_KEY_US * 1000 / INT_PERIOD_NS;
  localparam int BLANK_TICKS   = (BLANK_US * 1000 + INT_PERIOD_NS - 1) / INT_PERIOD_NS;
  localparam int DIGIT_TICKS   = DIGIT_US * 1000 / INT_PERIOD_NS;
  localparam int SLOT_TICKS    = BLANK_TICKS + DIGIT_TICKS;
  localparam int SCAN_LINES    = 8;

  // ***************************************************************
  // widths, reset values and command layout
  // ***************************************************************
  localparam int DEPTH      = 16;
  localparam int AW         = 4;
  localparam int DW         = 8;
  localparam logic [10:0] BUS_IDLE   = 11'h500;
  localparam logic [1:0]  MODE_RESET = 2'h0;
  localparam logic [3:0]  MASK_16    = 4'hF;
  localparam logic [3:0]  MASK_8     = 4'h7;
  localparam logic [2:0]  OP_MODE_SET   = 3'h0;
  localparam logic [2:0]  OP_WRITE_DISP = 3'h4;
  localparam int          OP_LSB        = 5;
  localparam int          AI_BIT        = 4;
  localparam int          RIGHT_BIT     = 4;
  localparam int          SIXTEEN_BIT   = 3;
  localparam int          CS_BIT        = 10;
  localparam int          A0_BIT        = 9;
  localparam int          WR_BIT        = 8;
  localparam logic [7:0]  CMD_NEXT_AT_5 = 8'h95;
  localparam logic [3:0]  ADDR_5        = 4'h5;

endpackage

// ---- disp_ram.sv ----
`timescale 1ns/1ps
module disp_ram
  import disp_scan_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] cells [DEPTH];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        cells[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (we) begin
        cells[wr_addr] <= wr_data;
      end
      rd_data <= cells[rd_addr];
    end
  end

endmodule

// ---- host_cpu_model.sv ----
`timescale 1ns/1ps
// ***************************************************************
// host cpu write port model
// ***************************************************************
module host_cpu_model (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            a0,
  output logic            wr_n,
  output logic      [7:0] data_in
);
  initial begin
    cs_n    = 1'b1;
    a0      = 1'b0;
    wr_n    = 1'b1;
    data_in = 8'h00;
  end

  // one byte write; sel_n high makes an unselected write
  task automatic put(input logic cmd, input logic [7:0] b, input logic sel_n);
    @(negedge clk);
    cs_n    = sel_n;
    a0      = cmd;
    data_in = b;
    wr_n    = 1'b0;
    repeat (6) @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
    cs_n    = 1'b1;
    data_in = ~b;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ---- right_entry_display_scan_tb_top.sv ----
`timescale 1ns/1ps
module right_entry_display_scan_tb_top;
  import disp_scan_pkg::*;
  localparam int p = 2;
  logic       clk = 1'b0;
  logic       rstn;
  logic       cs_n, a0, wr_n;
  logic [7:0] data_in;
  logic [3:0] scan, na, nb;
  logic       bdn, ks, ksd, dd;
  int         n_errors = 0;
  int         n_compared = 0;
  int         cycles = 0;

  // outside decoders on the scan lines
  wire [7:0]  key_row   = 8'h01 << scan[2:0];
  wire [15:0] digit_sel = 16'h0001 << scan;

  always #50 clk = ~clk;

  host_cpu_model i_host (.clk(clk), .cs_n(cs_n), .a0(a0), .wr_n(wr_n), .data_in(data_in));

  right_entry_display_scan #(.prescale(p)) i_dut (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .a0(a0), .wr_n(wr_n), .data_in(data_in),
    .scan_timing_outputs(scan), .display_nibble_a(na), .display_nibble_b(nb),
    .blank_display_n(bdn), .key_strobe(ks), .key_scan_done(ksd), .debounce_done(dd)
  );

  // ***************************************************************
  // checking and closing
  // ***************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      close_out;
    end
  end

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = ks;
      1: pick = ksd;
      2: pick = dd;
      3: pick = !bdn;
      default: pick = scan[0];
    endcase
  endfunction

  // high time and period of a selected output, in clk cycles
  task automatic measure(input int sel, output int hi, output int per);
    int k;
    k = 0;
    while (pick(sel) !== 1'b0 && k < 5000) begin tick; k++; end
    while (pick(sel) !== 1'b1 && k < 5000) begin tick; k++; end
    hi = 0;
    while (pick(sel) === 1'b1 && k < 5000) begin tick; hi++; k++; end
    per = hi;
    while (pick(sel) !== 1'b1 && k < 5000) begin tick; per++; k++; end
  endtask

  // waits for a digit slot, checks blanked then lit contents
  task automatic show(input logic [3:0] pos, input logic [7:0] exp);
    int k;
    k = 0;
    while (!(scan === pos && bdn === 1'b0) && k < 5000) begin tick; k++; end
    check({na, nb}, 16'h0000);
    check(key_row, 8'h01 << pos[2:0]);
    check(digit_sel, 16'h0001 << pos);
    while (bdn !== 1'b1 && k < 5000) begin tick; k++; end
    repeat (4) tick;
    check({na, nb}, {8'h00, exp});
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic test_timing;
    int hi, per;
    int hi_e[5];
    int per_e[5];
    hi_e  = '{1, 1, 1, 15 * p, 64 * p};
    per_e = '{8 * p, 512 * p, 1024 * p, 64 * p, 128 * p};
    for (int i = 0; i < 5; i++) begin
      measure(i, hi, per);
      check(hi[15:0], hi_e[i][15:0]);
      check(per[15:0], per_e[i][15:0]);
    end
    $display("test_timing done");
  endtask

  task automatic test_left;
    i_host.put(1'b0, 8'hA5, 1'b0);
    show(4'h0, 8'hA5);
    $display("test_left done");
  endtask

  task automatic test_right16;
    i_host.put(1'b1, 8'h18, 1'b0);
    i_host.put(1'b1, 8'h90, 1'b0);
    i_host.put(1'b0, 8'h11, 1'b0);
    show(4'h0, 8'h11);
    i_host.put(1'b0, 8'h22, 1'b0);
    show(4'h0, 8'h22);
    show(4'h1, 8'h11);
    i_host.put(1'b1, CMD_NEXT_AT_5, 1'b0);
    i_host.put(1'b0, 8'h33, 1'b0);
    i_host.put(1'b0, 8'h44, 1'b0);
    show(4'h0, 8'h00);
    show(4'h2, 8'h22);
    show(4'h3, 8'h11);
    show(4'hE, 8'h33);
    show(4'hD, 8'h44);
    $display("test_right16 done");
  endtask

  task automatic test_right8;
    i_host.put(1'b1, 8'h10, 1'b0);
    i_host.put(1'b1, 8'h90, 1'b0);
    i_host.put(1'b0, 8'h0A, 1'b0);
    i_host.put(1'b0, 8'h0B, 1'b0);
    i_host.put(1'b0, 8'h0C, 1'b0);
    i_host.put(1'b0, 8'hFF, 1'b1);
    show(4'h0, 8'h0C);
    show(4'h2, 8'h0A);
    show(4'h8, 8'h0C);
    show(4'h7, 8'h00);
    $display("test_right8 done");
  endtask

  initial begin
    rstn = 1'b0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    test_timing;
    test_left;
    test_right16;
    test_right8;
    close_out;
  end
endmodule
